// [rtl/serial_eeprom_pkg.sv]
package serial_eeprom_pkg;

  // Array shape
  localparam int WORD_COUNT = 16;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam int INSTR_BITS = 9;
  localparam int OP_BITS = 4;

  // Operation code patterns
  localparam logic [1:0] OP_HI_READ = 2'h2;
  localparam logic [1:0] OP_HI_WRITE = 2'h1;
  localparam logic [1:0] OP_HI_ERASE = 2'h3;
  localparam logic [1:0] OP_HI_MISC = 2'h0;
  localparam logic [1:0] OP_LO_UNLOCK = 2'h3;
  localparam logic [1:0] OP_LO_LOCK = 2'h0;
  localparam logic [1:0] OP_LO_ERASE_ALL = 2'h2;
  localparam logic [1:0] OP_LO_FILL_ALL = 2'h1;

  // Reset values
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic UNLOCK_RESET = 1'b0;
  localparam logic [4:0] COUNT_RESET = 5'h00;

  // Programming pulse limits, kept for the host side
  localparam int PULSE_MIN_MS = 10;
  localparam int PULSE_MAX_MS = 30;
  localparam int CLOCK_MHZ = 250;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INSTR = 3'h1,
    ST_DATA = 3'h3,
    ST_ARMED = 3'h2,
    ST_PROGRAM = 3'h6,
    ST_DONE = 3'h4,
    ST_READ = 3'h5
  } port_state_t;

  typedef enum logic [2:0] {
    PGM_NONE = 3'h0,
    PGM_ERASE = 3'h1,
    PGM_WRITE = 3'h2,
    PGM_ERASE_ALL = 3'h3,
    PGM_FILL_ALL = 3'h4
  } pgm_kind_t;

  // Serial pin group
  typedef struct packed {
    logic select;
    logic shift_clock;
    logic serial_in;
  } pins_in_t;

  typedef struct packed {
    logic serial_out;
    logic serial_out_en;
  } pins_out_t;

endpackage : serial_eeprom_pkg

// [rtl/serial_eeprom_16x16_port.sv]
// Summary of operation
// - Sixteen nonvolatile words of sixteen bits
// - Instruction opens with start marker one
// - Then four-bit opcode and four-bit address
// - 10xx read, 01xx write, 11xx erase
// - 0011 unlock, 0000 lock, 0010/0001 all-words
// - Serial output driven only during read
// - Read shifts dummy zero then sixteen bits
// - Output changes only while shift clock high
// - Programming needs unlock, lasts until lock or reset
// - Reads work locked or unlocked
// - Erase starts at select fall, sets ones
// - Write only clears bits to zero
// - Write data sixteen bits, MSB first
// - Programming ends when select rises
// - Pulse counted to later clock/select rise; here select rise alone ends it
// - Programming only for the four program kinds
// - Erase-everything sets all words to ones
// - Fill-everything writes pattern to all words
// - Select low outside programming means standby
`timescale 1ns/100ps
module serial_eeprom_16x16_port
  import serial_eeprom_pkg::*;
#(
  parameter int WORDS = WORD_COUNT,
  parameter int WIDTH = WORD_BITS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial pins from host
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_in,
  // Serial output pin
  output logic serial_out,
  output logic serial_out_en,
  // Status
  output logic programming,
  output logic standby
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0] sel_sync;
    logic [1:0] sck_sync;
    logic [1:0] din_sync;
    logic sel_prev;
    logic sck_prev;
    port_state_t state;
    logic [INSTR_BITS-2:0] shift_in;
    logic [4:0] count;
    logic [ADDR_BITS-1:0] addr;
    pgm_kind_t kind;
    logic [WIDTH-1:0] data;
    logic [WIDTH:0] shift_out;
    logic out_en;
    logic out_bit;
    logic unlocked;
    logic hv_on;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [WIDTH-1:0] mem_q [WORDS];
  logic mem_we;
  logic mem_all;
  logic [WIDTH-1:0] mem_wdata;
  logic mem_write_mode;

  logic sel;
  logic sck;
  logic din;
  logic sck_rise;
  logic sck_high;
  logic sel_fall;
  logic sel_rise;
  logic [INSTR_BITS-2:0] instr;

  // Fields of the instruction as its last bit arrives
  logic [OP_BITS-1:0] op_field;
  logic [ADDR_BITS-1:0] addr_field;
  logic dec_read;
  logic dec_unlock;
  logic dec_lock;
  logic dec_data;

  function automatic pgm_kind_t decode_pgm(input logic [OP_BITS-1:0] op);
    pgm_kind_t k;
    k = PGM_NONE;
    case (op[3:2])
      OP_HI_WRITE: k = PGM_WRITE;
      OP_HI_ERASE: k = PGM_ERASE;
      OP_HI_MISC:
      begin
        if (op[1:0] == OP_LO_ERASE_ALL)
          k = PGM_ERASE_ALL;
        else if (op[1:0] == OP_LO_FILL_ALL)
          k = PGM_FILL_ALL;
      end
      default: k = PGM_NONE;
    endcase
    return k;
  endfunction : decode_pgm

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic op_is_read(input logic [OP_BITS-1:0] op);
    return op[3:2] == OP_HI_READ;
  endfunction : op_is_read

  // Codes with upper bits 00 pick their action from the low bits
  function automatic logic op_is_misc(input logic [OP_BITS-1:0] op, input logic [1:0] low);
    return op == {OP_HI_MISC, low};
  endfunction : op_is_misc

  // Write and fill take sixteen data bits after the address
  function automatic logic op_takes_data(input logic [OP_BITS-1:0] op);
    return (op[3:2] == OP_HI_WRITE) || (op == {OP_HI_MISC, OP_LO_FILL_ALL});
  endfunction : op_takes_data

  function automatic logic kind_all_words(input pgm_kind_t k);
    return (k == PGM_ERASE_ALL) || (k == PGM_FILL_ALL);
  endfunction : kind_all_words

  // Write and fill can only clear bits
  function automatic logic kind_clears(input pgm_kind_t k);
    return (k == PGM_WRITE) || (k == PGM_FILL_ALL);
  endfunction : kind_clears

  // ==========================================================================
  // Synchronised pins and edges
  // ==========================================================================
  // Pins come from another clock and pass two stages first
  assign sel = s_q.sel_sync[1];
  assign sck = s_q.sck_sync[1];
  assign din = s_q.din_sync[1];
  assign sck_rise = sck & ~s_q.sck_prev;
  assign sck_high = sck;
  assign sel_fall = ~sel & s_q.sel_prev;
  assign sel_rise = sel & ~s_q.sel_prev;
  assign instr = {s_q.shift_in[INSTR_BITS-3:0], din};

  // ==========================================================================
  // Instruction decode
  // ==========================================================================
  assign op_field = instr[OP_BITS+ADDR_BITS-1:ADDR_BITS];
  assign addr_field = instr[ADDR_BITS-1:0];
  assign dec_read = op_is_read(op_field);
  assign dec_unlock = op_is_misc(op_field, OP_LO_UNLOCK);
  assign dec_lock = op_is_misc(op_field, OP_LO_LOCK);
  assign dec_data = op_takes_data(op_field);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_all = 1'b0;
    mem_wdata = ERASED_WORD;
    mem_write_mode = 1'b0;
    s_d.sel_sync = {s_q.sel_sync[0], select};
    s_d.sck_sync = {s_q.sck_sync[0], shift_clock};
    s_d.din_sync = {s_q.din_sync[0], serial_in};
    s_d.sel_prev = sel;
    s_d.sck_prev = sck;
    case (s_q.state)
      ST_IDLE:
      begin
        s_d.count = COUNT_RESET;
        // Start marker taken on a rising clock with input high
        if (sel && sck_rise && din)
        begin
          s_d.state = ST_INSTR;
          s_d.shift_in = '0;
        end
      end
      ST_INSTR:
      begin
        if (sck_rise)
        begin
          s_d.shift_in = instr;
          s_d.count = s_q.count + 5'h01;
          if (s_q.count == 5'(OP_BITS + ADDR_BITS - 1))
          begin
            s_d.count = COUNT_RESET;
            s_d.addr = addr_field;
            s_d.kind = decode_pgm(op_field);
            s_d.state = ST_IDLE;
            if (dec_read)
            begin
              s_d.shift_out = {1'b0, mem_q[addr_field]};
              s_d.state = ST_READ;
            end
            else if (dec_unlock)
            begin
              s_d.unlocked = 1'b1;
            end
            else if (dec_lock)
            begin
              s_d.unlocked = 1'b0;
            end
            else if (!s_q.unlocked)
            begin
              // Programming refused; array left untouched
              s_d.state = ST_IDLE;
            end
            else if (dec_data)
            begin
              s_d.state = ST_DATA;
            end
            else
            begin
              s_d.state = ST_ARMED;
            end
          end
        end
      end
      ST_DATA:
      begin
        // Sixteen data bits, most significant first
        if (sck_rise)
        begin
          s_d.data = {s_q.data[WIDTH-2:0], din};
          s_d.count = s_q.count + 5'h01;
          if (s_q.count == 5'(WIDTH - 1))
            s_d.state = ST_ARMED;
        end
      end
      ST_READ:
      begin
        // Load the output bit during the high phase only
        if (sck_high && !s_q.out_en)
        begin
          s_d.out_en = 1'b1;
          s_d.out_bit = s_q.shift_out[WIDTH];
        end
        else if (sck_rise)
          s_d.shift_out = {s_q.shift_out[WIDTH-1:0], 1'b0};
        else if (sck_high && s_q.out_en)
          s_d.out_bit = s_q.shift_out[WIDTH];
      end
      ST_ARMED:
      begin
        // Programming begins as select falls
        if (sel_fall)
        begin
          s_d.state = ST_PROGRAM;
          s_d.hv_on = 1'b1;
        end
      end
      ST_PROGRAM:
      begin
        // Cells are driven while select stays low
        mem_we = 1'b1;
        mem_all = kind_all_words(s_q.kind);
        mem_write_mode = kind_clears(s_q.kind);
        mem_wdata = mem_write_mode ? s_q.data : ERASED_WORD;
        if (sel_rise)
        begin
          s_d.hv_on = 1'b0;
          s_d.state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Back to idle once select is low or on the next shift clock rise
        if (!sel || sck_rise)
          s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase
    // Abort on select low outside programming
    if (!sel && s_q.state != ST_ARMED && s_q.state != ST_PROGRAM)
    begin
      s_d.state = ST_IDLE;
      s_d.out_en = 1'b0;
      s_d.out_bit = 1'b0;
      s_d.count = COUNT_RESET;
    end
    if (s_q.state != ST_READ)
      s_d.out_en = 1'b0;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q.sel_sync <= '0;
      s_q.sck_sync <= '0;
      s_q.din_sync <= '0;
      s_q.sel_prev <= '0;
      s_q.sck_prev <= '0;
      s_q.state <= ST_IDLE;
      s_q.shift_in <= '0;
      s_q.count <= COUNT_RESET;
      s_q.addr <= '0;
      s_q.kind <= PGM_NONE;
      s_q.data <= '0;
      s_q.shift_out <= '0;
      s_q.out_en <= '0;
      s_q.out_bit <= '0;
      s_q.unlocked <= UNLOCK_RESET;
      s_q.hv_on <= '0;
    end
    else
      s_q <= s_d;
  end

  // Array holds content across reset; erase and write are bitwise
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      if (mem_we && (mem_all || s_q.addr == ADDR_BITS'(i)))
        mem_q[i] <= mem_write_mode ? (mem_q[i] & mem_wdata) : mem_wdata;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign serial_out = s_q.out_bit;
  assign serial_out_en = s_q.out_en;
  assign programming = s_q.hv_on;
  assign standby = ~sel & ~s_q.hv_on;

endmodule : serial_eeprom_16x16_port

// [test/serial_eeprom_asserts.sv]
`timescale 1ns/100ps
module serial_eeprom_asserts
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial pins
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en,
  // Status
  input wire logic programming,
  input wire logic standby
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ====
  // Pin sequences
  sequence select_quiet;
    !select [*6];
  endsequence
  sequence select_back;
    $rose(select) ##0 programming;
  endsequence

  // ====
  // Checks
  standby_level_a: assert property (select_quiet |-> standby == !programming) else $error("standby");
  out_release_a: assert property (select_quiet |-> !serial_out_en) else $error("out not released");
  read_drive_a: assert property (serial_out_en |-> !programming) else $error("drive while pgm");
  dummy_bit_a: assert property ($rose(serial_out_en) |-> !serial_out) else $error("no dummy zero");
  out_change_a: assert property (serial_out_en && select && $changed(serial_out) |-> shift_clock) else $error("out");
  read_start_a: assert property ($rose(serial_out_en) |-> select && shift_clock) else $error("en rise");
  pgm_start_a: assert property ($rose(programming) |-> !select) else $error("pgm start");
  pgm_end_a: assert property (select_back |-> ##[1:5] !programming) else $error("pgm end");
endmodule : serial_eeprom_asserts

bind serial_eeprom_16x16_port serial_eeprom_asserts checker_inst (.clock(clock), .reset_n(reset_n), .select(select),
  .shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
  .programming(programming), .standby(standby));

// [test/eeprom_host.sv]
`timescale 1ns/100ps
module eeprom_host
(
  // Bench clock
  input wire logic clock,
  // Serial pins
  output logic select,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  initial
  begin
    select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end

  // ====
  // One 80 ns shift clock period, data set while low
  task tick(input logic b, output logic [1:0] seen);
    serial_in = b;
    repeat (10) @(negedge clock);
    shift_clock = 1'b1;
    repeat (8) @(negedge clock);
    // A released output shows the inverse of its last value
    seen = {serial_out_en, serial_out_en ? serial_out : ~serial_out};
    repeat (2) @(negedge clock);
    shift_clock = 1'b0;
  endtask : tick

  // ====
  // Whole frame; pulse is shortened as the device keeps no timer
  task frame(input logic [24:0] b, input int n, input int pulse, output logic [16:0] got, output logic en);
    logic [1:0] s;
    en = 1'b1;
    select = 1'b1;
    tick(1'b0, s);
    for (int i = 0; i < n; i++)
    begin
      tick(b[24 - i], s);
      if (i >= 8)
      begin
        got = {got[15:0], s[0]};
        en = en & s[1];
      end
    end
    select = 1'b0;
    serial_in = ~serial_in;
    repeat (pulse) @(negedge clock);
    if (pulse > 0)
    begin
      select = 1'b1;
      tick(1'b0, s);
      select = 1'b0;
      serial_in = 1'b1;
    end
    // Select stays low long enough for the device to see it
    repeat (4) @(negedge clock);
  endtask : frame
endmodule : eeprom_host

// [test/serial_eeprom_16x16_port_tb_top.sv]
`timescale 1ns/100ps
module serial_eeprom_16x16_port_tb_top;
  import serial_eeprom_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic select, shift_clock, serial_in, serial_out, serial_out_en, programming, standby;
  int errors = 0;
  int checks = 0;
  int pgm_cycles = 0;

  always #2 clock = ~clock;

  // Programming cycles, counted away from the launching edge
  always @(negedge clock)
    if (programming === 1'b1)
      pgm_cycles++;

  eeprom_host host (.clock(clock), .select(select), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));
  serial_eeprom_16x16_port uut (.clock(clock), .reset_n(reset_n), .select(select), .shift_clock(shift_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en), .programming(programming),
    .standby(standby));

  // ====
  // Helpers
  task chk(input logic [16:0] seen, input logic [16:0] want);
    checks++;
    if (seen !== want)
    begin
      errors++;
      $display("BAD %0t %h %h", $time, seen, want);
    end
  endtask : chk

  task results;
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task op(input logic [3:0] code, input logic [3:0] addr, input logic [15:0] data, input int n);
    logic [16:0] g;
    logic e;
    host.frame({1'b1, code, addr, data}, n, 50, g, e);
  endtask : op

  task rd(input logic [3:0] addr, input logic [15:0] want);
    logic [16:0] g;
    logic e;
    host.frame({1'b1, 4'h9, addr, 16'h0000}, 25, 0, g, e);
    chk(g, {1'b0, want});
    chk({16'h0000, e}, 17'h00001);
    repeat (6) @(negedge clock);
    chk({15'h0000, serial_out_en, standby}, 17'h00001);
  endtask : rd

  // ====
  // Scenarios
  task program_case;
    int p;
    op(4'h3, 4'h0, 16'h0000, 9);
    p = pgm_cycles;
    op(4'h2, 4'hA, 16'h0000, 9);
    chk({16'h0000, (pgm_cycles - p >= 49) && (pgm_cycles - p <= 51)}, 17'h00001);
    rd(4'h5, ERASED_WORD);
    op(4'h4, 4'h3, 16'hA5C3, 25);
    rd(4'h3, 16'hA5C3);
    op(4'h7, 4'h3, 16'h0FF0, 25);
    rd(4'h3, 16'h05C0);
    op(4'h1, 4'h9, 16'h7E7E, 25);
    rd(4'h3, 16'h0440);
    op(4'hE, 4'h3, 16'h0000, 9);
    rd(4'h3, ERASED_WORD);
    rd(4'h0, 16'h7E7E);
  endtask : program_case

  task abort_case;
    logic [16:0] g;
    logic e;
    int p;
    p = pgm_cycles;
    host.frame({1'b1, 4'h4, 4'h3, 16'h0000}, 12, 0, g, e);
    chk({16'h0000, pgm_cycles != p}, 17'h00000);
    rd(4'h3, ERASED_WORD);
  endtask : abort_case

  task lock_case;
    int p;
    op(4'h0, 4'h5, 16'h0000, 9);
    p = pgm_cycles;
    op(4'hC, 4'h0, 16'h0000, 9);
    op(4'h4, 4'h0, 16'h0000, 25);
    op(4'h2, 4'h0, 16'h0000, 9);
    chk({16'h0000, pgm_cycles != p}, 17'h00000);
    rd(4'h0, 16'h7E7E);
  endtask : lock_case

  // Reset in mid-run relocks programming and keeps the array
  task reset_case;
    op(4'h3, 4'h0, 16'h0000, 9);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    op(4'hC, 4'h0, 16'h0000, 9);
    rd(4'h0, 16'h7E7E);
  endtask : reset_case

  initial
  begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    program_case();
    abort_case();
    lock_case();
    reset_case();
    results();
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    errors++;
    results();
  end
endmodule : serial_eeprom_16x16_port_tb_top
